// ---- iorb_pkg.sv ----
// constants for the lower bit-reachable i/o register bank
// assumes one clock, synchronous active-high reset, core on same clock
//
// How it works
// - registers at 0x00..0x1f accept single-bit set and clear from the core
// - core may test one bit of these registers and skip on its value
// - some status flags clear when a one is written to them
// - single-bit set or clear touches only the addressed bit
// - bit operations honoured only for 0x00..0x1f, higher addresses not held here: writes ignored, reads zero
package iorb_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [4:0] OFS_TIMER1_OUTPUT_PIN_ENABLE = 5'h00;
	localparam logic [4:0] OFS_DIGITAL_INPUT_DISABLE_LOW = 5'h01;
	localparam logic [4:0] OFS_DIGITAL_INPUT_DISABLE_HIGH = 5'h02;
	localparam logic [4:0] OFS_CONVERTER_CONTROL_B = 5'h03;
	localparam logic [4:0] OFS_CONVERSION_RESULT_LOW = 5'h04;
	localparam logic [4:0] OFS_CONVERSION_RESULT_HIGH = 5'h05;
	localparam logic [4:0] OFS_CONVERTER_CONTROL_A = 5'h06;
	localparam logic [4:0] OFS_CONVERTER_CHANNEL_SELECT = 5'h07;
	localparam logic [4:0] OFS_COMPARATOR_CONTROL_A = 5'h08;
	localparam logic [4:0] OFS_COMPARATOR_CONTROL_B = 5'h09;
	localparam logic [4:0] OFS_SCRATCH_BYTE_ZERO = 5'h0a;
	localparam logic [4:0] OFS_SCRATCH_BYTE_ONE = 5'h0b;
	localparam logic [4:0] OFS_SCRATCH_BYTE_TWO = 5'h0c;
	localparam logic [4:0] OFS_SERIAL_IFACE_CONTROL = 5'h0d;
	localparam logic [4:0] OFS_SERIAL_IFACE_STATUS = 5'h0e;
	localparam logic [4:0] OFS_SERIAL_IFACE_SHIFT_DATA = 5'h0f;
	localparam logic [4:0] OFS_SERIAL_IFACE_BUFFER = 5'h10;
	localparam logic [4:0] OFS_SERIAL_IFACE_PIN_POSITION = 5'h11;
	localparam logic [4:0] OFS_TIMER0_COMPARE_B = 5'h12;
	localparam logic [4:0] OFS_TIMER0_COMPARE_A = 5'h13;
	localparam logic [4:0] OFS_TIMER0_COUNT_HIGH = 5'h14;
	localparam logic [4:0] OFS_TIMER0_CONTROL_A = 5'h15;
	localparam logic [4:0] OFS_PORT_B_INPUT_LEVEL = 5'h16;
	localparam logic [4:0] OFS_PORT_B_DIRECTION = 5'h17;
	localparam logic [4:0] OFS_PORT_B_OUTPUT = 5'h18;
	localparam logic [4:0] OFS_PORT_A_INPUT_LEVEL = 5'h19;
	localparam logic [4:0] OFS_PORT_A_DIRECTION = 5'h1a;
	localparam logic [4:0] OFS_PORT_A_OUTPUT = 5'h1b;
	localparam logic [4:0] OFS_EEPROM_CONTROL = 5'h1c;
	localparam int REG_COUNT = 29;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ----------------------------------------
	// software-writable bit masks (reserved, read-only and flag bits excluded)
	// ----------------------------------------
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_TIMER1_OUTPUT_PIN_ENABLE = 8'h3f;
	localparam logic [7:0] MASK_DIGITAL_INPUT_DISABLE_HIGH = 8'hf0;
	localparam logic [7:0] MASK_CONVERTER_CONTROL_B = 8'hdf;
	localparam logic [7:0] MASK_CONVERTER_CONTROL_A = 8'hef;
	localparam logic [7:0] MASK_COMPARATOR_CONTROL_A = 8'hcf;
	localparam logic [7:0] MASK_COMPARATOR_CONTROL_B = 8'hc7;
	localparam logic [7:0] MASK_SERIAL_IFACE_STATUS = 8'h1f;
	localparam logic [7:0] MASK_SERIAL_IFACE_PIN_POSITION = 8'h01;
	localparam logic [7:0] MASK_TIMER0_CONTROL_A = 8'hf9;
	localparam logic [7:0] MASK_EEPROM_CONTROL = 8'h3f;

	// ----------------------------------------
	// write-one-to-clear flags and other hardware bits
	// ----------------------------------------
	localparam int FLAG_COUNT = 5;
	localparam int FLAG_SERIAL_START = 0;
	localparam int FLAG_SERIAL_OVERFLOW = 1;
	localparam int FLAG_SERIAL_STOP = 2;
	localparam int FLAG_CONVERSION_DONE = 3;
	localparam int FLAG_COMPARATOR = 4;
	localparam logic [2:0] BIT_SERIAL_START = 3'h7;
	localparam logic [2:0] BIT_SERIAL_OVERFLOW = 3'h6;
	localparam logic [2:0] BIT_SERIAL_STOP = 3'h5;
	localparam logic [2:0] BIT_CONVERSION_DONE = 3'h4;
	localparam logic [2:0] BIT_COMPARATOR_FLAG = 3'h4;
	localparam int BIT_COMPARATOR_OUT = 5;
	localparam logic [4:0] FLAG_REG [FLAG_COUNT] = '{OFS_SERIAL_IFACE_STATUS,
		OFS_SERIAL_IFACE_STATUS, OFS_SERIAL_IFACE_STATUS, OFS_CONVERTER_CONTROL_A,
		OFS_COMPARATOR_CONTROL_A};
	localparam logic [2:0] FLAG_BIT [FLAG_COUNT] = '{BIT_SERIAL_START,
		BIT_SERIAL_OVERFLOW, BIT_SERIAL_STOP, BIT_CONVERSION_DONE, BIT_COMPARATOR_FLAG};

	// ----------------------------------------
	// writable mask per offset
	// ----------------------------------------
	function automatic logic [7:0] iorb_write_mask(input logic [4:0] ofs);
		logic [7:0] m;
		m = MASK_FULL;
		unique case (ofs)
			OFS_TIMER1_OUTPUT_PIN_ENABLE: m = MASK_TIMER1_OUTPUT_PIN_ENABLE;
			OFS_DIGITAL_INPUT_DISABLE_HIGH: m = MASK_DIGITAL_INPUT_DISABLE_HIGH;
			OFS_CONVERTER_CONTROL_B: m = MASK_CONVERTER_CONTROL_B;
			OFS_CONVERTER_CONTROL_A: m = MASK_CONVERTER_CONTROL_A;
			OFS_COMPARATOR_CONTROL_A: m = MASK_COMPARATOR_CONTROL_A;
			OFS_COMPARATOR_CONTROL_B: m = MASK_COMPARATOR_CONTROL_B;
			OFS_SERIAL_IFACE_STATUS: m = MASK_SERIAL_IFACE_STATUS;
			OFS_SERIAL_IFACE_PIN_POSITION: m = MASK_SERIAL_IFACE_PIN_POSITION;
			OFS_TIMER0_CONTROL_A: m = MASK_TIMER0_CONTROL_A;
			OFS_EEPROM_CONTROL: m = MASK_EEPROM_CONTROL;
			OFS_CONVERSION_RESULT_LOW, OFS_CONVERSION_RESULT_HIGH, OFS_SERIAL_IFACE_BUFFER,
			OFS_PORT_B_INPUT_LEVEL, OFS_PORT_A_INPUT_LEVEL: m = MASK_NONE;
			default: m = (ofs > OFS_EEPROM_CONTROL) ? MASK_NONE : MASK_FULL;
		endcase
		return m;
	endfunction : iorb_write_mask
endpackage : iorb_pkg

// ---- iorb_flag_if.sv ----
// carrier between the bank and one write-one-to-clear flag
// assumes owner and user share clk
`timescale 1ns/10ps
interface iorb_flag_if;
	logic hwSet;
	logic swClear;
	logic state;
	modport owner (input hwSet, input swClear, output state);
	modport user (output hwSet, output swClear, input state);
endinterface : iorb_flag_if

// ---- iorb_w1c_flag.sv ----
// one sticky status flag, set by hardware, cleared by writing one
// assumes the clear request is already decoded by the bank
`timescale 1ns/10ps
module iorb_w1c_flag
	import iorb_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	iorb_flag_if.owner fb
);
	// ----------------------------------------
	// flag storage
	// ----------------------------------------
	// set wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			fb.state <= 1'b0;
		else if (fb.hwSet)
			fb.state <= 1'b1;
		else if (fb.swClear)
			fb.state <= 1'b0;
	end

	flag_set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
		fb.hwSet |=> fb.state) else $error("flag lost a hardware set");
	flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!fb.hwSet && !fb.swClear |=> fb.state == $past(fb.state))
		else $error("flag moved without cause");
endmodule : iorb_w1c_flag

// ---- iorb_pin_sync.sv ----
// three-stage synchroniser for a group of port pins
// assumes pins change with no relation to clk
`timescale 1ns/10ps
module iorb_pin_sync
	import iorb_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pinRaw,
	output logic [WIDTH-1:0] pinLevel
);
	logic [WIDTH-1:0] stageOne;
	logic [WIDTH-1:0] stageTwo;
	logic [WIDTH-1:0] stageThree;

	// ----------------------------------------
	// sampling chain
	// ----------------------------------------
	// a bit changes only when stages two and three agree
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stageOne <= '0;
			stageTwo <= '0;
			stageThree <= '0;
			pinLevel <= '0;
		end
		else
		begin
			stageOne <= pinRaw;
			stageTwo <= stageOne;
			stageThree <= stageTwo;
			for (int i = 0; i < WIDTH; i++)
				if (stageTwo[i] == stageThree[i])
					pinLevel[i] <= stageThree[i];
		end
	end
endmodule : iorb_pin_sync

// ---- iorb_io_bank.sv ----
// lower i/o register bank, byte access plus single-bit set, clear, test
// assumes core drives one request per cycle on clk; peripherals on clk
`timescale 1ns/10ps
module iorb_io_bank
	import iorb_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [5:0] ioAddr,
	input wire logic [7:0] ioWriteData,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [2:0] bitSel,
	input wire logic singleBitSetOp,
	input wire logic singleBitClearOp,
	input wire logic skipIfBitSetOp,
	input wire logic skipIfBitClearOp,
	input wire logic [9:0] conversionResult,
	input wire logic [7:0] serialBuffer,
	input wire logic comparatorOut,
	input wire logic [FLAG_COUNT-1:0] flagEvent,
	input wire logic [7:0] portAPins,
	input wire logic [7:0] portBPins,
	output logic [7:0] ioReadData,
	output logic readValid,
	output logic skipNext,
	output logic testValid,
	output logic [7:0] regImage [REG_COUNT],
	output logic [FLAG_COUNT-1:0] flagState
);
	logic [4:0] regOfs;
	logic inBitRange;
	logic bitOpTaken;
	logic [7:0] liveByte [32];
	logic [7:0] portALevel;
	logic [7:0] portBLevel;
	logic [7:0] next_ioReadData;
	logic next_skip;
	logic [7:0] wrMask;
	logic [8*REG_COUNT-1:0] imageFlat;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// only the lower 32 addresses belong here and take bit operations
	assign regOfs = ioAddr[4:0];
	assign inBitRange = !ioAddr[5];
	assign bitOpTaken = inBitRange && (singleBitSetOp || singleBitClearOp);
	// writable bits of the addressed byte, read-only and flag bits excluded
	assign wrMask = iorb_write_mask(regOfs);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	iorb_pin_sync #(.WIDTH(8)) syncPortA (
		.clk(clk),
		.sys_rst(sys_rst),
		.pinRaw(portAPins),
		.pinLevel(portALevel)
	);

	iorb_pin_sync #(.WIDTH(8)) syncPortB (
		.clk(clk),
		.sys_rst(sys_rst),
		.pinRaw(portBPins),
		.pinLevel(portBLevel)
	);

	// ----------------------------------------
	// write-one-to-clear flags
	// ----------------------------------------
	iorb_flag_if flagBus [FLAG_COUNT] ();

	genvar g;
	generate
		for (g = 0; g < FLAG_COUNT; g++)
		begin : flagGen
			logic byteHit;
			logic bitHit;
			assign byteHit = inBitRange && ioWrite && regOfs == FLAG_REG[g];
			assign bitHit = bitOpTaken && singleBitSetOp && regOfs == FLAG_REG[g]
				&& bitSel == FLAG_BIT[g];
			// a written one clears, a written zero or a clear op leaves it
			assign flagBus[g].swClear = (byteHit && ioWriteData[FLAG_BIT[g]]) || bitHit;
			assign flagBus[g].hwSet = flagEvent[g];
			assign flagState[g] = flagBus[g].state;
			iorb_w1c_flag flagCell (
				.clk(clk),
				.sys_rst(sys_rst),
				.fb(flagBus[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// plain storage
	// ----------------------------------------
	// byte writes load writable bits; bit ops change one writable bit
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < REG_COUNT; i++)
				regImage[i] <= RESET_BYTE;
		end
		else if (inBitRange && int'(regOfs) < REG_COUNT)
		begin
			if (ioWrite)
				regImage[regOfs] <= (regImage[regOfs] & ~wrMask) | (ioWriteData & wrMask);
			else if (bitOpTaken && wrMask[bitSel])
				regImage[regOfs][bitSel] <= singleBitSetOp;
		end
	end

	// ----------------------------------------
	// live read view
	// ----------------------------------------
	// reserved bits read zero; hardware fields merged in
	always_comb
	begin
		for (int i = 0; i < 32; i++)
			liveByte[i] = (i < REG_COUNT) ? (regImage[i] & iorb_write_mask(5'(i))) : 8'h00;
		liveByte[OFS_CONVERSION_RESULT_LOW] = conversionResult[7:0];
		liveByte[OFS_CONVERSION_RESULT_HIGH] = {6'h00, conversionResult[9:8]};
		liveByte[OFS_SERIAL_IFACE_BUFFER] = serialBuffer;
		liveByte[OFS_PORT_A_INPUT_LEVEL] = portALevel;
		liveByte[OFS_PORT_B_INPUT_LEVEL] = portBLevel;
		liveByte[OFS_COMPARATOR_CONTROL_A][BIT_COMPARATOR_OUT] = comparatorOut;
		for (int f = 0; f < FLAG_COUNT; f++)
			liveByte[FLAG_REG[f]][FLAG_BIT[f]] = flagState[f];
	end

	// ----------------------------------------
	// read and bit-test answers
	// ----------------------------------------
	// addresses above the range answer zero here and never skip
	always_comb
	begin
		next_ioReadData = inBitRange ? liveByte[regOfs] : 8'h00;
		next_skip = 1'b0;
		if (inBitRange && skipIfBitSetOp)
			next_skip = liveByte[regOfs][bitSel];
		else if (inBitRange && skipIfBitClearOp)
			next_skip = !liveByte[regOfs][bitSel];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ioReadData <= 8'h00;
			readValid <= 1'b0;
		end
		else
		begin
			ioReadData <= next_ioReadData;
			readValid <= ioRead;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			skipNext <= 1'b0;
			testValid <= 1'b0;
		end
		else
		begin
			skipNext <= next_skip;
			testValid <= skipIfBitSetOp || skipIfBitClearOp;
		end
	end

	// ----------------------------------------
	// packed image
	// ----------------------------------------
	// one vector of all stored bytes, read by the range check only
	always_comb
	begin
		for (int i = 0; i < REG_COUNT; i++)
			imageFlat[8*i +: 8] = regImage[i];
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence scratchBitSet;
		singleBitSetOp && !ioWrite && ioAddr == {1'b0, OFS_SCRATCH_BYTE_ZERO};
	endsequence

	sequence scratchBitClear;
		singleBitClearOp && !singleBitSetOp && !ioWrite
			&& ioAddr == {1'b0, OFS_SCRATCH_BYTE_ZERO};
	endsequence

	bit_set_works_a: assert property (scratchBitSet |=>
		regImage[OFS_SCRATCH_BYTE_ZERO][$past(bitSel)])
		else $error("bit set did not take");

	bit_clear_works_a: assert property (scratchBitClear |=>
		!regImage[OFS_SCRATCH_BYTE_ZERO][$past(bitSel)])
		else $error("bit clear did not take");

	bit_op_isolated_a: assert property ((scratchBitSet or scratchBitClear) |=>
		((regImage[OFS_SCRATCH_BYTE_ZERO] ^ $past(regImage[OFS_SCRATCH_BYTE_ZERO]))
		& ~(8'h01 << $past(bitSel))) == 8'h00)
		else $error("bit op touched other bits");

	skip_test_a: assert property (inBitRange && skipIfBitSetOp |=>
		skipNext == $past(liveByte[regOfs][bitSel]) && testValid)
		else $error("skip answer wrong");

	high_bit_refused_a: assert property (ioAddr[5] && !ioWrite && !(|flagEvent) |=>
		$stable(imageFlat) && $stable(flagState))
		else $error("bit op above range changed state");

	flag_cleared_a: assert property (ioWrite && inBitRange
		&& regOfs == OFS_CONVERTER_CONTROL_A && ioWriteData[BIT_CONVERSION_DONE]
		&& !flagEvent[FLAG_CONVERSION_DONE] |=> !flagState[FLAG_CONVERSION_DONE])
		else $error("written one did not clear flag");

	zero_keeps_flag_a: assert property (ioWrite && inBitRange
		&& regOfs == OFS_COMPARATOR_CONTROL_A && !ioWriteData[BIT_COMPARATOR_FLAG]
		&& !singleBitSetOp && flagState[FLAG_COMPARATOR] |=> flagState[FLAG_COMPARATOR])
		else $error("written zero cleared flag");

	flag_event_seen_a: assert property (flagEvent[FLAG_COMPARATOR] |=>
		flagState[FLAG_COMPARATOR])
		else $error("flag event not seen");

	// ----------------------------------------
	// checks on read and test answers
	// ----------------------------------------
	// bytes above the range are not held here and read zero
	high_read_zero_a: assert property (ioRead && ioAddr[5] |=>
		readValid && ioReadData == 8'h00)
		else $error("high read not zero");

	// answers line up with the request one edge earlier
	scratch_read_a: assert property (ioRead
		&& ioAddr == {1'b0, OFS_SCRATCH_BYTE_ONE} |=> readValid
		&& ioReadData == $past(regImage[OFS_SCRATCH_BYTE_ONE]))
		else $error("read answer wrong");

	byte_write_lands_a: assert property (ioWrite
		&& ioAddr == {1'b0, OFS_SCRATCH_BYTE_TWO} |=>
		regImage[OFS_SCRATCH_BYTE_TWO] == $past(ioWriteData))
		else $error("byte write did not land");

	skip_clear_a: assert property (inBitRange && skipIfBitClearOp
		&& !skipIfBitSetOp |=> skipNext == !$past(liveByte[regOfs][bitSel]) && testValid)
		else $error("skip on clear answer wrong");

	high_skip_none_a: assert property (ioAddr[5]
		&& (skipIfBitSetOp || skipIfBitClearOp) |=> testValid && !skipNext)
		else $error("test above range skipped");

	test_pulse_a: assert property (!skipIfBitSetOp && !skipIfBitClearOp |=>
		!testValid && !skipNext)
		else $error("test answer without request");

	// ----------------------------------------
	// checks on bit ops near flags
	// ----------------------------------------
	// bit ops on the serial status byte, which holds three flags
	sequence statusBitSet;
		singleBitSetOp && !ioWrite && ioAddr == {1'b0, OFS_SERIAL_IFACE_STATUS};
	endsequence

	sequence statusBitClear;
		singleBitClearOp && !singleBitSetOp && !ioWrite
			&& ioAddr == {1'b0, OFS_SERIAL_IFACE_STATUS};
	endsequence

	// a set op on a flag bit clears it, a clear op never does
	set_op_clears_a: assert property (statusBitSet ##0
		(bitSel == BIT_SERIAL_OVERFLOW && !flagEvent[FLAG_SERIAL_OVERFLOW])
		|=> !flagState[FLAG_SERIAL_OVERFLOW])
		else $error("bit set did not clear flag");

	clear_op_keeps_a: assert property (statusBitClear ##0
		(bitSel == BIT_SERIAL_START && flagState[FLAG_SERIAL_START])
		|=> flagState[FLAG_SERIAL_START])
		else $error("bit clear wrote a flag");

	count_bits_spare_a: assert property (statusBitSet ##0
		(bitSel < BIT_SERIAL_STOP && !(|flagEvent)) |=> flagState == $past(flagState))
		else $error("bit set hit other flags");

	reserved_bit_a: assert property (singleBitSetOp
		&& ioAddr == {1'b0, OFS_TIMER1_OUTPUT_PIN_ENABLE} |=>
		regImage[OFS_TIMER1_OUTPUT_PIN_ENABLE][7:6] == 2'h0)
		else $error("bit set wrote reserved bit");
endmodule : iorb_io_bank

// ---- iorb_core_model.sv ----
// core model: issues byte, bit and test requests to the bank
// assumes each call starts just after a rising clk edge
`timescale 1ns/10ps
module iorb_core_model
(
	input wire logic clk,
	output logic [5:0] ioAddr,
	output logic [7:0] ioWriteData,
	output logic ioWrite,
	output logic ioRead,
	output logic [2:0] bitSel,
	output logic singleBitSetOp,
	output logic singleBitClearOp,
	output logic skipIfBitSetOp,
	output logic skipIfBitClearOp,
	input wire logic [7:0] ioReadData,
	input wire logic readValid,
	input wire logic skipNext,
	input wire logic testValid
);
	// ----------------------------------------
	// request driver
	// ----------------------------------------
	// idle bus at time zero
	initial
	begin
		{ioAddr, ioWriteData, bitSel} = 17'h00000;
		{ioWrite, ioRead, singleBitSetOp, singleBitClearOp} = 4'h0;
		{skipIfBitSetOp, skipIfBitClearOp} = 2'h0;
	end

	// kind: 0 write, 1 read, 2 set, 3 clear, 4 skip if set, 5 skip if clear
	task automatic issue(input int kind, input logic [5:0] a, input logic [2:0] b,
		input logic [7:0] d, output logic [7:0] rd, output logic vld);
		logic ok;
		ok = (a[4:0] < 5'h1d); // unassigned addresses never written
		ioAddr = a;
		ioWriteData = d;
		bitSel = b;
		ioWrite = (kind == 0) && ok;
		ioRead = (kind == 1);
		singleBitSetOp = (kind == 2) && ok;
		singleBitClearOp = (kind == 3) && ok;
		skipIfBitSetOp = (kind == 4);
		skipIfBitClearOp = (kind == 5);
		@(posedge clk);
		#1;
		rd = (kind == 1) ? ioReadData : {7'h00, skipNext};
		vld = (kind == 1) ? readValid : testValid;
		// released lines show the inverse, not the last value
		{ioWrite, ioRead, singleBitSetOp, singleBitClearOp} = 4'h0;
		{skipIfBitSetOp, skipIfBitClearOp} = 2'h0;
		ioAddr = ~a;
		ioWriteData = ~d;
		bitSel = ~b;
	endtask : issue
endmodule : iorb_core_model

// ---- io_register_bit_access_test.sv ----
// self-checking bench for the lower i/o register bank
// assumes core model drives requests, bench drives peripheral inputs
`timescale 1ns/10ps
module io_register_bit_access_test
	import iorb_pkg::*;
;
	logic clk, sys_rst, comparatorOut, ioWrite, ioRead, readValid, skipNext, testValid;
	logic singleBitSetOp, singleBitClearOp, skipIfBitSetOp, skipIfBitClearOp;
	logic [5:0] ioAddr;
	logic [2:0] bitSel;
	logic [9:0] conversionResult;
	logic [7:0] ioWriteData, serialBuffer, portAPins, portBPins, ioReadData;
	logic [4:0] flagEvent, flagState, fl;
	logic [7:0] regImage [REG_COUNT];
	logic [7:0] mem [32];
	logic [7:0] wmask [32] = '{8'h3f, 8'hff, 8'hf0, 8'hdf, 8'h00, 8'h00, 8'hef, 8'hff,
		8'hcf, 8'hc7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h00, 8'h01, 8'hff, 8'hff,
		8'hff, 8'hf9, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h3f, 8'h00, 8'h00, 8'h00};
	int flReg [5] = '{14, 14, 14, 6, 8};
	int flBit [5] = '{7, 6, 5, 4, 4};
	int nMismatch = 0;
	int nCompared = 0;

	iorb_io_bank dut_u (.clk, .sys_rst, .ioAddr, .ioWriteData, .ioWrite, .ioRead, .bitSel,
		.singleBitSetOp, .singleBitClearOp, .skipIfBitSetOp, .skipIfBitClearOp,
		.conversionResult, .serialBuffer, .comparatorOut, .flagEvent, .portAPins,
		.portBPins, .ioReadData, .readValid, .skipNext, .testValid, .regImage, .flagState);
	iorb_core_model core_u (.clk, .ioAddr, .ioWriteData, .ioWrite, .ioRead, .bitSel,
		.singleBitSetOp, .singleBitClearOp, .skipIfBitSetOp, .skipIfBitClearOp,
		.ioReadData, .readValid, .skipNext, .testValid);

	// ----------------------------------------
	// clock, compare and verdict
	// ----------------------------------------
	// 40 mhz clock
	always #12.5 clk = ~clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		nCompared++;
		if (seen !== want)
		begin
			nMismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic finish_test;
		if (nMismatch == 0 && nCompared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	// expected byte as read by the core
	function automatic logic [7:0] exp_read(input int a);
		logic [7:0] v;
		v = mem[a];
		if (a == 4) v = conversionResult[7:0];
		if (a == 5) v = {6'h00, conversionResult[9:8]};
		if (a == 16) v = serialBuffer;
		if (a == 22) v = portBPins;
		if (a == 25) v = portAPins;
		if (a == 8) v[5] = comparatorOut;
		for (int i = 0; i < 5; i++)
			if (flReg[i] == a) v[flBit[i]] = fl[i];
		return v;
	endfunction : exp_read

	// one request with flag events in the same cycle, then model update
	task automatic op(input int kind, input int a, input int b, input logic [7:0] d,
		input logic [4:0] ev);
		logic [7:0] rd, e;
		logic vld, hit;
		e = (a < 32) ? exp_read(a) : 8'h00; // bank holds only the low range
		@(posedge clk);
		#1;
		flagEvent = ev;
		core_u.issue(kind, 6'(a), 3'(b), d, rd, vld);
		flagEvent = 5'h00;
		if (kind == 1)
			check({rd[7:1], rd[0] & vld}, e | {7'h00, ~vld});
		if (kind >= 4)
			check({6'h00, vld, rd[0]}, {7'h01, (a < 32) && (e[b] ^ (kind == 5))});
		for (int i = 0; i < 5; i++)
		begin
			hit = (flReg[i] == a) && ((kind == 0 && d[flBit[i]]) || (kind == 2 && b == flBit[i]));
			if (ev[i])
				fl[i] = 1'b1;
			else if (hit)
				fl[i] = 1'b0;
		end
		if (kind == 0 && a < 29)
			mem[a] = d & wmask[a];
		if (kind == 2 && a < 32)
			mem[a][b] = mem[a][b] | wmask[a][b];
		if (kind == 3 && a < 32)
			mem[a][b] = 1'b0;
		check({3'h0, flagState}, {3'h0, fl});
		if (a % 32 < 29)
			check(regImage[a % 32] & wmask[a % 32], mem[a % 32]);
	endtask : op

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	// hang guard
	initial
	begin
		repeat (60000) @(posedge clk);
		nMismatch++;
		finish_test();
	end

	// reset, then scenarios
	initial
	begin
		int k, a;
		logic [7:0] d;
		{clk, sys_rst, comparatorOut, conversionResult, serialBuffer} = 21'h080000;
		{flagEvent, fl, portAPins, portBPins} = 26'h0;
		for (int i = 0; i < 32; i++)
			mem[i] = 8'h00;
		void'($urandom(12));
		repeat (10) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (int i = 0; i < 32; i++)
			op(1, i, 0, 8'h00, 5'h00);
		conversionResult = 10'($urandom);
		serialBuffer = 8'($urandom);
		comparatorOut = 1'($urandom);
		portAPins = 8'($urandom);
		portBPins = 8'($urandom);
		repeat (6) @(posedge clk);
		for (int i = 0; i < 29; i++)
			op(0, i, 0, 8'($urandom) & wmask[i], 5'h00); // reserved bits zero
		// every bit cleared, tested, set, tested, starting with all flags up
		op(1, 0, 0, 8'h00, 5'h1f);
		for (int i = 0; i < 29; i++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				op(3, i, b, 8'h00, 5'h00);
				op(5, i, b, 8'h00, 5'h00);
				op(2, i, b, 8'h00, 5'h00);
				op(4, i, b, 8'h00, 5'h00);
			end
			if (i < 28)
			begin
				op(3, i + 32, $urandom % 8, 8'h00, 5'h00);
				op(4, i + 32, $urandom % 8, 8'h00, 5'h00);
				op(1, i + 32, 0, 8'h00, 5'h00);
			end
			op(1, i, 0, 8'h00, 5'h00);
		end
		// flags: zero write, set beating clear, one write
		for (int i = 0; i < 5; i++)
		begin
			op(1, flReg[i], 0, 8'h00, 5'(1 << i));
			op(0, flReg[i], 0, 8'h00, 5'h00);
			op(0, flReg[i], 0, 8'(1 << flBit[i]), 5'(1 << i));
			op(0, flReg[i], 0, 8'(1 << flBit[i]), 5'h00);
			op(1, flReg[i], 0, 8'h00, 5'h00);
		end
		// random mix with flag events
		repeat (600)
		begin
			k = $urandom % 6;
			a = $urandom % 29;
			d = 8'($urandom) & wmask[a];
			for (int i = 0; i < 5; i++)
				if (flReg[i] == a && $urandom % 2) d[flBit[i]] = 1'b1;
			op(k, a, $urandom % 8, d, 5'($urandom) & 5'($urandom));
		end
		finish_test();
	end
endmodule : io_register_bit_access_test
